// >>> src/frb_pkg.sv
package frb_pkg;

  // widths
  localparam int INSTR_W = 14;
  localparam int DATA_W  = 8;
  localparam int FIDX_W  = 7;
  localparam int BPOS_W  = 3;
  localparam int FLAG_W  = 3;
  localparam int ADDR_W  = 10;
  localparam int BUS_W   = 32;
  localparam int BE_W    = 4;
  localparam int CNT_W   = 16;
  localparam int NIB_W   = 4;
  localparam int FILE_N  = 128;

  // instruction word fields
  localparam int CLS_HI = 13;
  localparam int CLS_LO = 12;
  localparam int OP_HI  = 11;
  localparam int OP_LO  = 8;
  localparam int DST_B  = 7;
  localparam int BOP_HI = 11;
  localparam int BOP_LO = 10;
  localparam int BIT_HI = 9;
  localparam int BIT_LO = 7;
  localparam int FID_HI = 6;
  localparam int FID_LO = 0;

  // encodings
  localparam logic [1:0] CLS_BYTE = 2'h0;
  localparam logic [1:0] CLS_BIT  = 2'h1;
  localparam logic [3:0] OP_ADD   = 4'h7;
  localparam logic [3:0] OP_AND   = 4'h5;
  localparam logic [1:0] BOP_CLR  = 2'h0;
  localparam logic [1:0] BOP_SET  = 2'h1;

  // flag positions
  localparam int FLG_C  = 0;
  localparam int FLG_DC = 1;
  localparam int FLG_Z  = 2;

  // register byte addresses
  localparam logic [9:0] OFS_INSTR = 10'h000;
  localparam logic [9:0] OFS_ACC   = 10'h004;
  localparam logic [9:0] OFS_FLAGS = 10'h008;
  localparam logic [9:0] OFS_STAT  = 10'h00C;
  localparam logic [9:0] OFS_LRES  = 10'h010;
  localparam logic [9:0] OFS_COUNT = 10'h014;
  localparam int         FILE_SEL_B = 9;
  localparam int         FILE_IDX_HI = 8;
  localparam int         FILE_IDX_LO = 2;
  localparam int         STAT_UNSUP  = 0;

  // reset values
  localparam logic [7:0]  ACC_RST   = 8'h00;
  localparam logic [2:0]  FLAGS_RST = 3'h0;
  localparam logic [13:0] INSTR_RST = 14'h0000;
  localparam logic [15:0] CNT_RST   = 16'h0000;

  typedef enum logic [2:0] {
    FRB_SEL_INSTR,
    FRB_SEL_ACC,
    FRB_SEL_FLAGS,
    FRB_SEL_STAT,
    FRB_SEL_LRES,
    FRB_SEL_COUNT,
    FRB_SEL_FILE,
    FRB_SEL_NONE
  } frb_sel_t;

endpackage

// >>> src/frb_alu.sv
`timescale 1ns/100ps
module frb_alu (
  // instruction and operands
  input  wire logic [13:0] instr_i,
  input  wire logic [7:0]  acc_i,
  input  wire logic [7:0]  fval_i,
  // result and routing
  output logic      [7:0]  res_o,
  output logic             wr_acc_o,
  output logic             wr_file_o,
  output logic      [2:0]  fmask_o,
  output logic      [2:0]  fnew_o,
  output logic             unsup_o
);

  logic [1:0] cls;
  logic [3:0] op;
  logic [1:0] bop;
  logic [2:0] bpos;
  logic       dst;
  logic [8:0] sum;
  logic [4:0] nib;
  logic [7:0] bmask;

  assign cls  = instr_i[frb_pkg::CLS_HI:frb_pkg::CLS_LO];
  assign op   = instr_i[frb_pkg::OP_HI:frb_pkg::OP_LO];
  assign bop  = instr_i[frb_pkg::BOP_HI:frb_pkg::BOP_LO];
  assign bpos = instr_i[frb_pkg::BIT_HI:frb_pkg::BIT_LO];
  assign dst  = instr_i[frb_pkg::DST_B];
  assign sum  = {1'b0, acc_i} + {1'b0, fval_i};
  assign nib  = {1'b0, acc_i[frb_pkg::NIB_W-1:0]} +
                {1'b0, fval_i[frb_pkg::NIB_W-1:0]};

  // one-hot selector for the addressed bit
  genvar g;
  generate
    for (g = 0; g < frb_pkg::DATA_W; g++) begin : g_bmask
      assign bmask[g] = (bpos == 3'(g));
    end
  endgenerate

  always_comb begin
    res_o     = fval_i;
    wr_acc_o  = 1'b0;
    wr_file_o = 1'b0;
    fmask_o   = 3'h0;
    fnew_o    = 3'h0;
    unsup_o   = 1'b0;
    if (cls == frb_pkg::CLS_BYTE && op == frb_pkg::OP_ADD) begin
      res_o                = sum[frb_pkg::DATA_W-1:0];
      fmask_o              = 3'h7;
      fnew_o[frb_pkg::FLG_C]  = sum[frb_pkg::DATA_W];
      fnew_o[frb_pkg::FLG_DC] = nib[frb_pkg::NIB_W];
      fnew_o[frb_pkg::FLG_Z]  = (sum[frb_pkg::DATA_W-1:0] == 8'h00);
      wr_acc_o  = ~dst;
      wr_file_o = dst;
    end else if (cls == frb_pkg::CLS_BYTE && op == frb_pkg::OP_AND) begin
      res_o                  = acc_i & fval_i;
      fmask_o[frb_pkg::FLG_Z] = 1'b1;
      fnew_o[frb_pkg::FLG_Z]  = ((acc_i & fval_i) == 8'h00);
      wr_acc_o  = ~dst;
      wr_file_o = dst;
    end else if (cls == frb_pkg::CLS_BIT && bop == frb_pkg::BOP_CLR) begin
      res_o     = fval_i & ~bmask;
      wr_file_o = 1'b1;
    end else if (cls == frb_pkg::CLS_BIT && bop == frb_pkg::BOP_SET) begin
      res_o     = fval_i | bmask;
      wr_file_o = 1'b1;
    end else begin
      unsup_o = 1'b1;
    end
  end

endmodule

// >>> src/frb_file_reg_alu.sv
// Overview of operation
// - add accumulator and register, update C DC Z
// - destination bit picks accumulator or register
// - and accumulator with register, update Z
// - clear or set one bit, flags untouched
//
// Added by the designer: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/100ps
module frb_file_reg_alu (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // avalon-mm slave
  input  wire logic [9:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  // core state
  output logic      [7:0]  acc_o,
  output logic      [2:0]  flags_o
);

  ////////////////////////////////////////////////////////////////////////////
  // address decode
  // map: 000 word to execute, 004 accumulator, 008 flags,
  // 00C sticky unsupported flag (write one clears), 010 last result,
  // 014 executed count, 200 + 4 * index the file registers

  function automatic frb_pkg::frb_sel_t frb_decode(input logic [9:0] a);
    frb_pkg::frb_sel_t s;
    s = frb_pkg::FRB_SEL_NONE;
    if (a[frb_pkg::FILE_SEL_B] && a[1:0] == 2'h0) begin
      s = frb_pkg::FRB_SEL_FILE;
    end else begin
      case (a)
        frb_pkg::OFS_INSTR: s = frb_pkg::FRB_SEL_INSTR;
        frb_pkg::OFS_ACC:   s = frb_pkg::FRB_SEL_ACC;
        frb_pkg::OFS_FLAGS: s = frb_pkg::FRB_SEL_FLAGS;
        frb_pkg::OFS_STAT:  s = frb_pkg::FRB_SEL_STAT;
        frb_pkg::OFS_LRES:  s = frb_pkg::FRB_SEL_LRES;
        frb_pkg::OFS_COUNT: s = frb_pkg::FRB_SEL_COUNT;
        default:            s = frb_pkg::FRB_SEL_NONE;
      endcase
    end
    return s;
  endfunction

  // lanes a register needs before a write counts
  function automatic logic frb_lanes_ok(input frb_pkg::frb_sel_t s,
                                        input logic [3:0]        be);
    logic ok;
    ok = be[0];
    if (s == frb_pkg::FRB_SEL_INSTR) begin
      ok = be[0] && be[1];
    end
    return ok;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  frb_pkg::frb_sel_t sel;

  logic [7:0]  acc_q,   acc_d;
  logic [2:0]  flags_q, flags_d;
  logic [13:0] instr_q, instr_d;
  logic [7:0]  lres_q,  lres_d;
  logic [15:0] cnt_q,   cnt_d;
  logic        unsup_q, unsup_d;
  logic        rdone_q, rdone_d;
  logic [31:0] rdata_q, rdata_d;

  // file registers, one byte each
  logic [7:0]  file_mem [frb_pkg::FILE_N];
  logic        mem_we;
  logic [6:0]  mem_idx;
  logic [7:0]  mem_wdata;

  logic [13:0] ex_instr;
  logic [6:0]  ex_idx;
  logic [7:0]  ex_fval;
  logic [7:0]  alu_res;
  logic        alu_wr_acc;
  logic        alu_wr_file;
  logic [2:0]  alu_fmask;
  logic [2:0]  alu_fnew;
  logic        alu_unsup;

  logic        wr_go;
  logic        rd_go;
  logic        exec;
  logic        stat_clr;
  logic        wr_ok;
  logic        ex_ok;
  logic [6:0]  bus_idx;

  ////////////////////////////////////////////////////////////////////////////
  // operand fetch and alu

  assign sel      = frb_decode(avs_address_i);
  // word index of a file register on the bus
  assign bus_idx  = avs_address_i[frb_pkg::FILE_IDX_HI:frb_pkg::FILE_IDX_LO];
  assign ex_instr = avs_writedata_i[frb_pkg::INSTR_W-1:0];
  assign ex_idx   = ex_instr[frb_pkg::FID_HI:frb_pkg::FID_LO];
  // read half of the read-modify-write
  assign ex_fval  = file_mem[ex_idx];

  frb_alu u_alu (
    .instr_i   (ex_instr),
    .acc_i     (acc_q),
    .fval_i    (ex_fval),
    .res_o     (alu_res),
    .wr_acc_o  (alu_wr_acc),
    .wr_file_o (alu_wr_file),
    .fmask_o   (alu_fmask),
    .fnew_o    (alu_fnew),
    .unsup_o   (alu_unsup)
  );

  ////////////////////////////////////////////////////////////////////////////
  // bus handshake

  // writes never wait; reads wait one cycle for registered data
  // read and write together is illegal: both ignored, wait held high
  assign wr_go             = avs_write_i && !avs_read_i;
  assign rd_go             = avs_read_i && !avs_write_i && !rdone_q;
  assign avs_waitrequest_o = avs_read_i && !rdone_q;
  assign avs_readdata_o    = rdata_q;
  assign acc_o             = acc_q;
  assign flags_o           = flags_q;

  // a write counts only with the lanes its register needs
  assign wr_ok = wr_go && frb_lanes_ok(sel, avs_byteenable_i);

  // a full instruction word executes in the edge that takes it
  assign exec = wr_ok && sel == frb_pkg::FRB_SEL_INSTR;

  // writing one clears the sticky unsupported flag
  assign stat_clr = wr_ok && sel == frb_pkg::FRB_SEL_STAT &&
                    avs_writedata_i[frb_pkg::STAT_UNSUP];

  ////////////////////////////////////////////////////////////////////////////
  // execute and register writes

  // accepted word that the alu can carry out
  assign ex_ok = exec && !alu_unsup;

  // core state: accumulator and flags
  always_comb begin
    acc_d   = acc_q;
    flags_d = flags_q;
    // an unsupported word leaves both untouched
    if (ex_ok) begin
      if (alu_wr_acc) begin
        acc_d = alu_res;
      end
      flags_d = (flags_q & ~alu_fmask) | (alu_fnew & alu_fmask);
    end else if (wr_ok) begin
      case (sel)
        frb_pkg::FRB_SEL_ACC: begin
          acc_d = avs_writedata_i[frb_pkg::DATA_W-1:0];
        end
        frb_pkg::FRB_SEL_FLAGS: begin
          flags_d = avs_writedata_i[frb_pkg::FLAG_W-1:0];
        end
        default: begin
          acc_d = acc_q;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc_q   <= frb_pkg::ACC_RST;
      flags_q <= frb_pkg::FLAGS_RST;
    end else begin
      acc_q   <= acc_d;
      flags_q <= flags_d;
    end
  end

  // bookkeeping: last word, last result, count, unsupported flag
  always_comb begin
    instr_d = instr_q;
    lres_d  = lres_q;
    cnt_d   = cnt_q;
    // sticky unsupported flag, a new set wins over a clear
    unsup_d = (unsup_q && !stat_clr) || (exec && alu_unsup);
    // an unsupported word is latched but not counted
    if (exec) begin
      instr_d = ex_instr;
    end
    if (ex_ok) begin
      lres_d = alu_res;
      cnt_d  = cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      instr_q <= frb_pkg::INSTR_RST;
      lres_q  <= frb_pkg::ACC_RST;
      cnt_q   <= frb_pkg::CNT_RST;
      unsup_q <= 1'b0;
    end else begin
      instr_q <= instr_d;
      lres_q  <= lres_d;
      cnt_q   <= cnt_d;
      unsup_q <= unsup_d;
    end
  end

  // file register write port
  always_comb begin
    mem_we    = 1'b0;
    mem_idx   = bus_idx;
    mem_wdata = avs_writedata_i[frb_pkg::DATA_W-1:0];
    if (ex_ok && alu_wr_file) begin
      mem_we    = 1'b1;
      mem_idx   = ex_idx;
      mem_wdata = alu_res;
    end else if (wr_ok && sel == frb_pkg::FRB_SEL_FILE) begin
      mem_we = 1'b1;
    end
  end

  // file registers hold no reset value
  always_ff @(posedge clk_i) begin
    if (mem_we) begin
      file_mem[mem_idx] <= mem_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path

  // one wait state, the data come from a register
  always_comb begin
    rdone_d = 1'b0;
    // data are loaded in the first cycle, handed over in the second
    if (rd_go) begin
      rdone_d = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdone_q <= 1'b0;
    end else begin
      rdone_q <= rdone_d;
    end
  end

  // read data, upper bits zero
  always_comb begin
    rdata_d = rdata_q;
    if (rd_go) begin
      rdata_d = 32'h0000_0000;
      case (sel)
        frb_pkg::FRB_SEL_INSTR: begin
          rdata_d[frb_pkg::INSTR_W-1:0] = instr_q;
        end
        frb_pkg::FRB_SEL_ACC: begin
          rdata_d[frb_pkg::DATA_W-1:0] = acc_q;
        end
        frb_pkg::FRB_SEL_FLAGS: begin
          rdata_d[frb_pkg::FLAG_W-1:0] = flags_q;
        end
        frb_pkg::FRB_SEL_STAT: begin
          rdata_d[frb_pkg::STAT_UNSUP] = unsup_q;
        end
        frb_pkg::FRB_SEL_LRES: begin
          rdata_d[frb_pkg::DATA_W-1:0] = lres_q;
        end
        frb_pkg::FRB_SEL_COUNT: begin
          rdata_d[frb_pkg::CNT_W-1:0] = cnt_q;
        end
        frb_pkg::FRB_SEL_FILE: begin
          // never-written file registers read as unknown
          rdata_d[frb_pkg::DATA_W-1:0] = file_mem[bus_idx];
        end
        default: begin
          rdata_d = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

endmodule

// >>> tb/frb_file_reg_alu_sva.sv
`timescale 1ns/100ps
module frb_file_reg_alu_sva (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // bus and core state
  input wire logic [9:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0]  avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  input wire logic [7:0]  acc_o,
  input wire logic [2:0]  flags_o
);
  logic       ex;
  logic [5:0] hi;
  logic       add_x;
  logic       and_x;
  logic       bit_x;
  logic       d;
  //////////////////////////////
  // executing instruction write
  assign ex = avs_write_i && !avs_read_i && avs_byteenable_i[1:0] == 2'h3 &&
              avs_address_i == frb_pkg::OFS_INSTR;
  assign hi    = avs_writedata_i[13:8];
  assign d     = avs_writedata_i[7];
  assign add_x = ex && hi == {frb_pkg::CLS_BYTE, frb_pkg::OP_ADD};
  assign and_x = ex && hi == {frb_pkg::CLS_BYTE, frb_pkg::OP_AND};
  assign bit_x = ex && hi[5:4] == frb_pkg::CLS_BIT && !hi[3];
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_add_zero: assert property (add_x && !d |=>
    flags_o[2] == (acc_o == 8'h00)) else $error("add zero flag wrong");
  a_add_carry: assert property (add_x && !d |=>
    flags_o[0] == (acc_o < $past(acc_o))) else $error("add carry wrong");
  a_add_nibble: assert property (add_x && !d |=>
    flags_o[1] == (acc_o[3:0] < $past(acc_o[3:0])))
    else $error("add nibble carry wrong");
  a_dest_file: assert property ((add_x || and_x) && d |=>
    $stable(acc_o)) else $error("accumulator changed on file dest");
  a_and_flags: assert property (and_x |=>
    flags_o[1:0] == $past(flags_o[1:0])) else $error("and touched carry");
  a_and_bits: assert property (and_x && !d |=>
    (acc_o & ~$past(acc_o)) == 8'h00) else $error("and set a bit");
  a_and_zero: assert property (and_x && !d |=>
    flags_o[2] == (acc_o == 8'h00)) else $error("and zero flag wrong");
  a_bit_quiet: assert property (bit_x |=>
    $stable(flags_o) && $stable(acc_o)) else $error("bit op changed state");
  c_add_carry: cover property (add_x && !d ##1 flags_o[0]);
  c_and_zero: cover property (and_x && !d ##1 flags_o[2]);
  c_bit_op: cover property (bit_x);
endmodule

bind frb_file_reg_alu frb_file_reg_alu_sva u_sva (
  .clk_i(clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .acc_o(acc_o), .flags_o(flags_o));

// >>> tb/frb_host_model.sv
`timescale 1ns/100ps
module frb_host_model (
  // clock
  input  wire logic        clk_i,
  // avalon-mm master
  output logic      [9:0]  address_o,
  output logic             read_o,
  output logic             write_o,
  output logic      [31:0] writedata_o,
  output logic      [3:0]  byteenable_o,
  input  wire logic [31:0] readdata_i,
  input  wire logic        waitrequest_i
);
  logic timed_out;
  initial begin
    {address_o, read_o, write_o, writedata_o, byteenable_o} = '0;
    timed_out = 1'b0;
  end
  //////////////////////////////
  // one transfer, held until waitrequest low or 64 cycles have passed
  task automatic xfer(input logic rd, input logic [9:0] a,
                      input logic [31:0] dt, output logic [31:0] q);
    int n;
    n = 0;
    address_o    <= a;
    writedata_o  <= dt;
    byteenable_o <= 4'hF;
    read_o       <= rd;
    write_o      <= !rd;
    do begin
      @(posedge clk_i);
      n++;
    end while (waitrequest_i && n < 64);
    timed_out = waitrequest_i;
    q = readdata_i;
    read_o      <= 1'b0;
    write_o     <= 1'b0;
    // idle bus shows inverted values
    address_o   <= ~a;
    writedata_o <= ~dt;
    @(posedge clk_i);
  endtask
endmodule

// >>> tb/frb_file_reg_alu_tb_top.sv
`timescale 1ns/100ps
module frb_file_reg_alu_tb_top;
  logic        clk_i;
  logic        rst_i;
  logic [9:0]  avs_address_i;
  logic        avs_read_i;
  logic        avs_write_i;
  logic [31:0] avs_writedata_i;
  logic [3:0]  avs_byteenable_i;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic [7:0]  acc_o;
  logic [2:0]  flags_o;
  logic [31:0] q;
  int          errors;
  int          n_tests;
  // acc, operand, sum, flags
  logic [31:0] t [4] = '{32'h17C2D900, 32'h88780007, 32'h0F011002,
                         32'hF0201001};

  always #20 clk_i = ~clk_i;

  frb_file_reg_alu u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .acc_o(acc_o), .flags_o(flags_o));

  frb_host_model u_host (
    .clk_i(clk_i), .address_o(avs_address_i), .read_o(avs_read_i),
    .write_o(avs_write_i), .writedata_o(avs_writedata_i),
    .byteenable_o(avs_byteenable_i), .readdata_i(avs_readdata_o),
    .waitrequest_i(avs_waitrequest_o));

  //////////////////////////////
  task automatic close_out();
    $display("checks=%0d errors=%0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic xf(input logic rd, input logic [9:0] a, input logic [31:0] d);
    u_host.xfer(rd, a, d, q);
    if (u_host.timed_out) begin
      errors++;
      close_out();
    end
  endtask

  function automatic logic [9:0] fa(input logic [6:0] f);
    return 10'h200 + {1'b0, f, 2'h0};
  endfunction

  function automatic logic [13:0] bw(input logic [3:0] op, input logic d,
                                     input logic [6:0] f);
    return {frb_pkg::CLS_BYTE, op, d, f};
  endfunction

  function automatic logic [13:0] bb(input logic [1:0] op,
                                     input logic [2:0] b, input logic [6:0] f);
    return {frb_pkg::CLS_BIT, op, b, f};
  endfunction

  task automatic exe(input logic [13:0] w);
    xf(1'b0, frb_pkg::OFS_INSTR, {18'h0, w});
  endtask

  task automatic prep(input logic [7:0] a, input logic [6:0] f,
                      input logic [7:0] v, input logic [2:0] fl);
    xf(1'b0, frb_pkg::OFS_ACC, {24'h0, a});
    xf(1'b0, fa(f), {24'h0, v});
    xf(1'b0, frb_pkg::OFS_FLAGS, {29'h0, fl});
  endtask

  function automatic logic [31:0] st();
    return {21'h0, flags_o, acc_o};
  endfunction

  initial begin
    clk_i = 1'b0;
    rst_i = 1'b1;
    errors = 0;
    n_tests = 0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk(st(), 32'h0);
    for (int i = 0; i < 4; i++) begin
      prep(t[i][31:24], 7'h7F, t[i][23:16], 3'h0);
      exe(bw(frb_pkg::OP_ADD, 1'b0, 7'h7F));
      chk(st(), {21'h0, t[i][2:0], t[i][15:8]});
    end
    prep(8'h17, 7'h05, 8'hC2, 3'h0);
    exe(bw(frb_pkg::OP_ADD, 1'b1, 7'h05));
    chk(st(), 32'h17);
    xf(1'b1, fa(7'h05), 32'h0);
    chk(q, 32'hD9);
    prep(8'h17, 7'h06, 8'hC2, 3'h3);
    exe(bw(frb_pkg::OP_AND, 1'b1, 7'h06));
    chk(st(), 32'h317);
    xf(1'b1, fa(7'h06), 32'h0);
    chk(q, 32'h02);
    prep(8'hF0, 7'h06, 8'h0F, 3'h3);
    exe(bw(frb_pkg::OP_AND, 1'b0, 7'h06));
    chk(st(), 32'h700);
    for (int b = 0; b < 8; b++) begin
      prep(8'h5A, 7'h00, 8'hC7, 3'h5);
      exe(bb(frb_pkg::BOP_CLR, b[2:0], 7'h00));
      xf(1'b1, fa(7'h00), 32'h0);
      chk(q, {24'h0, 8'hC7 & ~(8'h01 << b)});
      exe(bb(frb_pkg::BOP_SET, b[2:0], 7'h00));
      xf(1'b1, fa(7'h00), 32'h0);
      chk(q, {24'h0, 8'hC7 | (8'h01 << b)});
      chk(st(), 32'h55A);
    end
    xf(1'b1, frb_pkg::OFS_COUNT, 32'h0);
    chk(q, 32'h17);
    xf(1'b1, frb_pkg::OFS_LRES, 32'h0);
    chk(q, 32'hC7);
    xf(1'b1, frb_pkg::OFS_INSTR, 32'h0);
    chk(q, 32'h1780);
    // unsupported bit op: sticky flag set and word latched, nothing counted
    exe(bb(2'h2, 3'h0, 7'h00));
    xf(1'b1, frb_pkg::OFS_STAT, 32'h0);
    chk(q, 32'h1);
    xf(1'b1, frb_pkg::OFS_COUNT, 32'h0);
    chk(q, 32'h17);
    chk(st(), 32'h55A);
    xf(1'b0, frb_pkg::OFS_STAT, 32'h1);
    xf(1'b1, frb_pkg::OFS_STAT, 32'h0);
    chk(q, 32'h0);
    xf(1'b1, 10'h0FC, 32'h0);
    chk(q, 32'h0);
    close_out();
  end
endmodule
